/* logic/byte_fifo.sv */
// Small valid/ready FIFO used in the program data path
`default_nettype none
module byte_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic flush,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_q, rd_q;
  logic [AW:0] cnt_q;
  logic push, pop;

  // Honest flags from the occupancy count
  assign in_ready = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data = mem[rd_q];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // Storage write
  always_ff @(posedge clk)
  begin
    if (push)
    begin
      mem[wr_q] <= in_data;
    end
  end

  // Pointers and count; flush drops everything
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end
    else if (flush)
    begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
      end
      if (pop)
      begin
        rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule
`default_nettype wire

/* logic/flash_pe_pkg.sv */
// Shared constants and carrier types for the flash program/erase sequencer
`default_nettype none
package flash_pe_pkg;
  // Opcodes
  localparam logic [7:0] OP_WRITE_LATCH_SET_CMD_SET = 8'h06;
  localparam logic [7:0] OP_PAGE_WRITE = 8'h02;
  localparam logic [7:0] OP_QUAD_PAGE_WRITE = 8'h32;
  localparam logic [7:0] OP_WIPE_SECTOR = 8'h20;
  localparam logic [7:0] OP_WIPE_BLOCK32 = 8'h52;
  localparam logic [7:0] OP_WIPE_BLOCK64 = 8'hD8;
  localparam logic [7:0] OP_WIPE_ARRAY_A = 8'h60;
  localparam logic [7:0] OP_WIPE_ARRAY_B = 8'hC7;
  localparam logic [7:0] OP_STATUS_READ = 8'h05;
  // Status bit positions
  localparam int STAT_WIP_BIT = 0;
  localparam int STAT_WEL_BIT = 1;
  // Geometry
  localparam int ADDR_W = 24;
  localparam int PAGE_BYTES = 256;
  localparam int FIFO_DEPTH = 8;
  localparam int DATA_W = 8;
  // Timing in microseconds and clock rate
  localparam int CLK_MHZ = 125;
  localparam int PAGE_WRITE_TIME_US = 350;
  localparam int WIPE_SECTOR_TIME_US = 40000;
  localparam int WIPE_BLOCK_TIME_US = 150000;
  localparam int WIPE_ARRAY_TIME_US = 2500000;
  localparam longint PAGE_WRITE_CYC = longint'(PAGE_WRITE_TIME_US) * CLK_MHZ;
  localparam longint WIPE_SECTOR_CYC = longint'(WIPE_SECTOR_TIME_US) * CLK_MHZ;
  localparam longint WIPE_BLOCK_CYC = longint'(WIPE_BLOCK_TIME_US) * CLK_MHZ;
  localparam longint WIPE_ARRAY_CYC = longint'(WIPE_ARRAY_TIME_US) * CLK_MHZ;
  localparam int TIMER_W = 32;
  // Kind of self-timed job
  typedef enum logic [2:0] {JOB_PAGE, JOB_SECTOR, JOB_BLK32, JOB_BLK64, JOB_ARRAY} job_kind_t;
  // Byte handed to the array side
  typedef struct packed {
    logic [7:0] offset;
    logic [7:0] data;
  } page_byte_t;
  // Job handed to the array port
  typedef struct packed {
    job_kind_t kind;
    logic [ADDR_W-1:0] addr;
  } job_t;
endpackage
`default_nettype wire

/* logic/flash_pe_seq.sv */
// Serial flash program and erase command sequencer
// What this block does
// - Data past the page end wraps to the page start.
// - Over 256 bytes: only the last 256 are programmed.
// - Under 256 bytes: only addressed bytes change, the rest untouched.
// - Program runs only if select rises right after a whole data byte.
// - Select rise starts page_write_time cycle with write_in_progress high.
// - Write enable latch clears before each self-timed cycle ends.
// - Status reads are served during a running program or erase.
// - Page program to a protected page is not executed.
// - Quad page write 32H uses four lines, only when quad permit set.
// - Sector erase 20H accepts any address inside the sector.
// - Erase runs only if select rises right after last address byte.
// - Sector erase runs wipe_sector_time with write_in_progress high.
// - Opcode 52H erases the 32KB block holding the address.
// - Opcode D8H erases the 64KB block holding the address.
// - Block erase runs wipe_block_time with write_in_progress high.
// - Erase aimed at a protected region is refused.
// - Array erase 60H or C7H needs select rise after the opcode.
// - Array erase runs wipe_array_time with write_in_progress high.
// - Array erase is ignored when any sector is protected.
// - Host bits are sampled on the rising serial clock edge.
// - Opcode 05H shifts out status bits 7 to 0.
`default_nettype none
module flash_pe_seq
  import flash_pe_pkg::*;
#(
  parameter longint PAGE_CYC = PAGE_WRITE_CYC,
  parameter longint SECTOR_CYC = WIPE_SECTOR_CYC,
  parameter longint BLOCK_CYC = WIPE_BLOCK_CYC,
  parameter longint ARRAY_CYC = WIPE_ARRAY_CYC
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic select_n,
  input wire logic serial_clk,
  input wire logic [3:0] quad_io_in,
  output logic [3:0] quad_io_out,
  output logic [3:0] quad_io_oe,
  input wire logic quad_mode_permit,
  input wire logic [4:0] protect_region_bits,
  input wire logic [ADDR_W-1:0] protect_lo,
  input wire logic [ADDR_W-1:0] protect_hi,
  output logic write_in_progress,
  output logic write_enable_latch,
  output logic [7:0] status_byte,
  output logic job_valid,
  output flash_pe_pkg::job_t job,
  output logic page_byte_valid,
  output flash_pe_pkg::page_byte_t page_byte,
  output logic [PAGE_BYTES-1:0] page_mask
);
  import flash_pe_pkg::*;

  typedef enum {ST_OPCODE, ST_ADDR, ST_DATA, ST_STATUS, ST_SKIP} phase_t;

  // Two flip-flop synchronisers for every pin input
  logic [2:0] sel_sync_q, sck_sync_q;
  logic [3:0] io_m_q, io_s_q;
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      sel_sync_q <= 3'h7;
      sck_sync_q <= 3'h0;
      io_m_q <= 4'h0;
      io_s_q <= 4'h0;
    end
    else
    begin
      sel_sync_q <= {sel_sync_q[1:0], select_n};
      sck_sync_q <= {sck_sync_q[1:0], serial_clk};
      io_m_q <= quad_io_in;
      io_s_q <= io_m_q;
    end
  end

  logic sel_act, sck_rise, sck_fall, sel_rise;
  assign sel_act = !sel_sync_q[1];
  assign sck_rise = sck_sync_q[1] && !sck_sync_q[2] && sel_act;
  assign sck_fall = !sck_sync_q[1] && sck_sync_q[2] && sel_act;
  assign sel_rise = sel_sync_q[1] && !sel_sync_q[2];

  // True when an address range overlaps the protected window
  function automatic logic is_protected(input logic [ADDR_W-1:0] lo, input logic [ADDR_W-1:0] hi);
    is_protected = (protect_region_bits != 5'h00) && (hi >= protect_lo) && (lo <= protect_hi);
  endfunction

  phase_t phase_q;
  logic [7:0] opcode_q;
  logic [ADDR_W-1:0] addr_q;
  logic [7:0] shift_q;
  logic [5:0] bit_cnt_q;
  logic [1:0] addr_bytes_q;
  logic quad_q;
  logic [8:0] data_cnt_q;
  logic [7:0] wr_off_q;
  logic byte_done;
  logic [7:0] next_shift;
  logic [5:0] width;

  // Bits per edge: four in quad data/address, one otherwise
  assign width = (quad_q && phase_q != ST_OPCODE) ? 6'h04 : 6'h01;
  assign next_shift = (width == 6'h04) ? {shift_q[3:0], io_s_q} : {shift_q[6:0], io_s_q[0]};
  assign byte_done = sck_rise && ((bit_cnt_q + width) == 6'h08);

  logic fifo_in_ready, fifo_out_valid, fifo_pop;
  page_byte_t fifo_out;
  logic timer_busy;
  logic is_prog_op, is_erase_op, is_array_op;
  assign is_prog_op = (opcode_q == OP_PAGE_WRITE) ||
                      (opcode_q == OP_QUAD_PAGE_WRITE && quad_mode_permit);
  assign is_erase_op = (opcode_q == OP_WIPE_SECTOR) || (opcode_q == OP_WIPE_BLOCK32) ||
                       (opcode_q == OP_WIPE_BLOCK64);
  assign is_array_op = (opcode_q == OP_WIPE_ARRAY_A) || (opcode_q == OP_WIPE_ARRAY_B);

  // Command framing: opcode, address, then data or status shifting
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      phase_q <= ST_OPCODE;
      opcode_q <= 8'h00;
      addr_q <= '0;
      shift_q <= 8'h00;
      bit_cnt_q <= 6'h00;
      addr_bytes_q <= 2'h0;
      quad_q <= 1'b0;
      data_cnt_q <= 9'h000;
      wr_off_q <= 8'h00;
    end
    else if (!sel_act)
    begin
      phase_q <= ST_OPCODE;
      bit_cnt_q <= 6'h00;
      addr_bytes_q <= 2'h0;
      quad_q <= 1'b0;
    end
    else if (sck_rise)
    begin
      shift_q <= next_shift;
      bit_cnt_q <= byte_done ? 6'h00 : bit_cnt_q + width;
      if (byte_done)
      begin
        case (phase_q)
          ST_OPCODE:
          begin
            opcode_q <= next_shift;
            data_cnt_q <= 9'h000;
            quad_q <= (next_shift == OP_QUAD_PAGE_WRITE) && quad_mode_permit;
            if (next_shift == OP_STATUS_READ)
            begin
              phase_q <= ST_STATUS;
            end
            else if (!timer_busy && (next_shift == OP_PAGE_WRITE ||
                     (next_shift == OP_QUAD_PAGE_WRITE && quad_mode_permit) ||
                     next_shift == OP_WIPE_SECTOR || next_shift == OP_WIPE_BLOCK32 ||
                     next_shift == OP_WIPE_BLOCK64))
            begin
              phase_q <= ST_ADDR;
            end
            else
            begin
              phase_q <= ST_SKIP;
            end
          end
          ST_ADDR:
          begin
            addr_q <= {addr_q[15:0], next_shift};
            addr_bytes_q <= addr_bytes_q + 2'h1;
            if (addr_bytes_q == 2'h2)
            begin
              phase_q <= ST_DATA;
              wr_off_q <= next_shift;
            end
          end
          ST_DATA:
          begin
            wr_off_q <= wr_off_q + 8'h01;
            if (data_cnt_q != 9'h1FF)
            begin
              data_cnt_q <= data_cnt_q + 9'h001;
            end
          end
          // A byte after an opcode-only command voids it
          ST_SKIP:
          begin
            opcode_q <= 8'h00;
          end
          default:
          begin
            phase_q <= phase_q;
          end
        endcase
      end
    end
  end

  // Status byte presented on the output line
  logic [7:0] stat_q;
  logic [2:0] stat_bit_q;
  assign stat_q = {6'h00, write_enable_latch, write_in_progress};
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      quad_io_out <= 4'h0;
      quad_io_oe <= 4'h0;
      stat_bit_q <= 3'h7;
      status_byte <= 8'h00;
    end
    else
    begin
      status_byte <= stat_q;
      if (phase_q != ST_STATUS)
      begin
        quad_io_oe <= 4'h0;
        stat_bit_q <= 3'h7;
      end
      else if (sck_fall)
      begin
        quad_io_oe <= 4'h2;
        quad_io_out <= {2'h0, stat_q[stat_bit_q], 1'b0};
        stat_bit_q <= stat_bit_q - 3'h1;
      end
    end
  end

  // Data bytes queue through the FIFO into the page buffer
  logic data_push;
  page_byte_t data_in;
  assign data_push = byte_done && phase_q == ST_DATA;
  assign data_in = '{offset: wr_off_q, data: next_shift};
  byte_fifo #(.WIDTH(16), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .rstn(rstn),
    .flush(sel_act && phase_q == ST_OPCODE),
    .in_valid(data_push),
    .in_ready(fifo_in_ready),
    .in_data(data_in),
    .out_valid(fifo_out_valid),
    .out_ready(1'b1),
    .out_data(fifo_out)
  );
  assign fifo_pop = fifo_out_valid;

  // Page buffer: last byte per offset wins, mask marks touched bytes
  logic [7:0] page_mem [PAGE_BYTES];
  logic [PAGE_BYTES-1:0] mask_q;
  always_ff @(posedge clk)
  begin
    if (fifo_pop)
    begin
      page_mem[fifo_out.offset] <= fifo_out.data;
    end
  end
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      mask_q <= '0;
    end
    else if (sel_act && phase_q == ST_OPCODE)
    begin
      mask_q <= '0;
    end
    else if (fifo_pop)
    begin
      mask_q[fifo_out.offset] <= 1'b1;
    end
  end

  // Decide at select rise whether the framed command runs
  logic go_prog, go_erase, go_array;
  logic [ADDR_W-1:0] lo_a, hi_a;
  always_comb
  begin
    lo_a = addr_q;
    hi_a = addr_q;
    case (opcode_q)
      OP_WIPE_SECTOR: begin lo_a = {addr_q[23:12], 12'h000}; hi_a = {addr_q[23:12], 12'hFFF}; end
      OP_WIPE_BLOCK32: begin lo_a = {addr_q[23:15], 15'h0000}; hi_a = {addr_q[23:15], 15'h7FFF}; end
      OP_WIPE_BLOCK64: begin lo_a = {addr_q[23:16], 16'h0000}; hi_a = {addr_q[23:16], 16'hFFFF}; end
      default: begin lo_a = {addr_q[23:8], 8'h00}; hi_a = {addr_q[23:8], 8'hFF}; end
    endcase
  end
  assign go_prog = sel_rise && write_enable_latch && !timer_busy && is_prog_op &&
                   phase_q == ST_DATA && bit_cnt_q == 6'h00 && data_cnt_q != 9'h000 &&
                   !is_protected(lo_a, hi_a);
  assign go_erase = sel_rise && write_enable_latch && !timer_busy && is_erase_op &&
                    phase_q == ST_DATA && data_cnt_q == 9'h000 && bit_cnt_q == 6'h00 &&
                    !is_protected(lo_a, hi_a);
  assign go_array = sel_rise && write_enable_latch && !timer_busy && is_array_op &&
                    phase_q == ST_SKIP && bit_cnt_q == 6'h00 &&
                    protect_region_bits == 5'h00;

  // Self-timed cycle counter and status latches
  logic [TIMER_W-1:0] timer_q;
  assign timer_busy = write_in_progress;
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      timer_q <= '0;
      write_in_progress <= 1'b0;
      write_enable_latch <= 1'b0;
      job_valid <= 1'b0;
      job <= '0;
      page_mask <= '0;
    end
    else
    begin
      job_valid <= 1'b0;
      if (go_prog)
      begin
        timer_q <= TIMER_W'(PAGE_CYC - 1);
        write_in_progress <= 1'b1;
        job_valid <= 1'b1;
        job <= '{kind: JOB_PAGE, addr: {addr_q[23:8], 8'h00}};
        page_mask <= mask_q;
      end
      else if (go_erase)
      begin
        timer_q <= (opcode_q == OP_WIPE_SECTOR) ? TIMER_W'(SECTOR_CYC - 1) :
                   TIMER_W'(BLOCK_CYC - 1);
        write_in_progress <= 1'b1;
        job_valid <= 1'b1;
        job <= '{kind: (opcode_q == OP_WIPE_SECTOR) ? JOB_SECTOR :
                 (opcode_q == OP_WIPE_BLOCK32) ? JOB_BLK32 : JOB_BLK64, addr: lo_a};
      end
      else if (go_array)
      begin
        timer_q <= TIMER_W'(ARRAY_CYC - 1);
        write_in_progress <= 1'b1;
        job_valid <= 1'b1;
        job <= '{kind: JOB_ARRAY, addr: '0};
      end
      else if (write_in_progress)
      begin
        if (timer_q == '0)
        begin
          write_in_progress <= 1'b0;
        end
        else
        begin
          timer_q <= timer_q - 1'b1;
        end
        if (timer_q == TIMER_W'(1))
        begin
          write_enable_latch <= 1'b0;
        end
      end
      if (sel_rise && phase_q == ST_SKIP && bit_cnt_q == 6'h00 && opcode_q == OP_WRITE_LATCH_SET_CMD_SET &&
          !write_in_progress)
      begin
        write_enable_latch <= 1'b1;
      end
    end
  end

  // Page byte stream to the array port
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      page_byte_valid <= 1'b0;
      page_byte <= '0;
    end
    else
    begin
      page_byte_valid <= fifo_pop;
      page_byte <= fifo_out;
    end
  end

  // Busy flag and latch agree with the timer; quad mode and array erase obey permit and protection
  wip_hold_a: assert property (@(posedge clk) disable iff (!rstn)
    go_prog |=> write_in_progress [*8]) else $error("busy dropped early");
  wel_gate_a: assert property (@(posedge clk) disable iff (!rstn)
    (sel_rise && !write_enable_latch) |=> !job_valid) else $error("job without latch");
  wel_clear_a: assert property (@(posedge clk) disable iff (!rstn)
    $fell(write_in_progress) |-> !write_enable_latch) else $error("latch set at end");
  quad_gate_a: assert property (@(posedge clk) disable iff (!rstn)
    (quad_q) |-> quad_mode_permit || $past(quad_mode_permit)) else $error("quad w/o permit");
  array_prot_a: assert property (@(posedge clk) disable iff (!rstn)
    go_array |-> protect_region_bits == 5'h00) else $error("array erase protected");
  job_start_a: assert property (@(posedge clk) disable iff (!rstn)
    (go_prog || go_erase || go_array) |=> job_valid && write_in_progress) else $error("no job");
endmodule
`default_nettype wire

/* tb/flash_pe_seq_test.sv */
// Self-checking bench for the flash program and erase sequencer
`default_nettype none
module flash_pe_seq_test;
  import flash_pe_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int PC = 600;
  localparam int SC = 30;
  localparam int BC = 50;
  localparam int AC = 70;
  typedef logic [7:0] bq_t[$];
  typedef struct {job_kind_t kind; logic [23:0] am; logic [23:0] addr; logic [255:0] m;} note_t;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic select_n, serial_clk, write_in_progress, write_enable_latch, job_valid, page_byte_valid;
  logic quad_mode_permit = 1'b0;
  logic [3:0] quad_io_in, quad_io_out, quad_io_oe;
  logic [4:0] protect_region_bits = 5'h00;
  logic [23:0] protect_lo = 24'h000000;
  logic [23:0] protect_hi = 24'h000000;
  logic [7:0] status_byte;
  job_t job;
  page_byte_t page_byte;
  logic [255:0] page_mask;
  logic [7:0] pat [256];
  note_t notes[$];
  note_t nt;
  int fail_count = 0;
  int check_count = 0;
  int seed = 33053;
  int cyc = 0;
  int run_len = 0;
  int last_len = 0;
  logic [7:0] ops [5] = '{OP_WIPE_SECTOR, OP_WIPE_BLOCK32, OP_WIPE_BLOCK64, OP_WIPE_ARRAY_A,
                         OP_WIPE_ARRAY_B};
  job_kind_t kinds [5] = '{JOB_SECTOR, JOB_BLK32, JOB_BLK64, JOB_ARRAY, JOB_ARRAY};
  logic [23:0] ams [5] = '{24'hFFF000, 24'hFF8000, 24'hFF0000, 24'h000000, 24'h000000};
  int lens [5] = '{SC, BC, BC, AC, AC};

  initial
  begin
    forever #4 clk = ~clk;
  end

  flash_pe_seq #(.PAGE_CYC(PC), .SECTOR_CYC(SC), .BLOCK_CYC(BC), .ARRAY_CYC(AC)) dut_u (
    .clk(clk), .rstn(rstn), .select_n(select_n), .serial_clk(serial_clk),
    .quad_io_in(quad_io_in), .quad_io_out(quad_io_out), .quad_io_oe(quad_io_oe),
    .quad_mode_permit(quad_mode_permit), .protect_region_bits(protect_region_bits),
    .protect_lo(protect_lo), .protect_hi(protect_hi), .write_in_progress(write_in_progress),
    .write_enable_latch(write_enable_latch), .status_byte(status_byte), .job_valid(job_valid),
    .job(job), .page_byte_valid(page_byte_valid), .page_byte(page_byte), .page_mask(page_mask));

  spi_host_model host_u (.clk(clk), .select_n(select_n), .serial_clk(serial_clk),
    .quad_io_in(quad_io_in), .dev_out(quad_io_out), .dev_oe(quad_io_oe));

  task automatic chk(input string nm, input logic [255:0] e, input logic [255:0] s);
    check_count++;
    if (s !== e)
    begin
      fail_count++;
      $display("BAD %s expected %0h seen %0h", nm, e, s);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // Watchdog, busy length, and the queue of expected jobs
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 95000)
    begin
      fail_count++;
      end_of_test();
    end
    if (write_in_progress === 1'b1)
      run_len++;
    else if (run_len != 0)
    begin
      last_len = run_len;
      run_len = 0;
    end
    if (rstn && job_valid === 1'b1)
    begin
      if (notes.size() == 0)
        chk("job", 1'b0, 1'b1);
      else
      begin
        nt = notes.pop_front();
        chk("kind", nt.kind, job.kind);
        chk("addr", nt.addr & nt.am, job.addr & nt.am);
        if (nt.kind == JOB_PAGE)
          chk("mask", nt.m, page_mask);
      end
    end
    // Data is a fixed function of offset, so wrapped or repeated bytes still match
    if (rstn && page_byte_valid === 1'b1)
      chk("byte", pat[page_byte.offset], page_byte.data);
  end

  function automatic bq_t frm(logic [7:0] op, logic [23:0] a, int n);
    bq_t q;
    q = {op, a[23:16], a[15:8], a[7:0]};
    for (int i = 0; i < n; i++)
      q.push_back(pat[8'(a[7:0] + i)]);
    return q;
  endfunction

  function automatic logic [255:0] msk(logic [7:0] o, int n);
    logic [255:0] m;
    m = '0;
    for (int i = 0; i < n; i++)
      m[8'(o + i)] = 1'b1;
    return m;
  endfunction

  task automatic write_latch_set_cmd();
    logic [7:0] r;
    host_u.frame({OP_WRITE_LATCH_SET_CMD_SET}, 0, 1'b0, 0, r);
    @(posedge clk);
    #1;
    chk("wel_set", 1'b1, write_enable_latch);
  endtask

  task automatic run(input bq_t q, input int tail, input bit quad, input bit ok,
                     input job_kind_t k, input logic [23:0] am, input logic [255:0] m,
                     input int len, input bit poll);
    logic [7:0] st;
    int w;
    note_t n;
    n.kind = k;
    n.am = am;
    n.addr = q.size() > 3 ? {q[1], q[2], q[3]} : 24'h000000;
    n.m = m;
    if (ok)
      notes.push_back(n);
    host_u.frame(q, tail, quad, 0, st);
    w = 0;
    while (write_in_progress !== 1'b1 && w < 10)
    begin
      @(posedge clk);
      w++;
    end
    chk("busy", ok, write_in_progress);
    if (ok)
    begin
      if (poll)
      begin
        host_u.frame({OP_STATUS_READ}, 0, 1'b0, 8, st);
        chk("status", 2'h3, st[1:0]);
        chk("status_pins", 2'h3, status_byte[1:0]);
      end
      w = 0;
      while (write_in_progress !== 1'b0 && w < len + 20)
      begin
        @(posedge clk);
        w++;
      end
      @(posedge clk);
      #1;
      chk("wip_len", 1'b1, last_len >= len - 1 && last_len <= len + 3);
      chk("wel_clear", 1'b0, write_enable_latch);
    end
    @(posedge clk);
    #1;
  endtask

  initial
  begin
    bq_t q;
    logic [23:0] a;
    for (int i = 0; i < 256; i++)
      pat[i] = 8'($random(seed));
    repeat (12) @(posedge clk);
    #1;
    rstn = 1'b1;
    repeat (4) @(posedge clk);
    // Program without the latch, then a wrapping, an overlong and a cut frame
    run(frm(OP_PAGE_WRITE, 24'h001200, 8), 0, 0, 0, JOB_PAGE, 0, 0, 0, 0);
    write_latch_set_cmd();
    run(frm(OP_PAGE_WRITE, 24'h0012F0, 20), 0, 0, 1, JOB_PAGE, 24'hFFFF00, msk(8'hF0, 20), PC, 1);
    write_latch_set_cmd();
    run(frm(OP_PAGE_WRITE, 24'h003410, 257), 0, 0, 1, JOB_PAGE, 24'hFFFF00, msk(0, 256), PC, 0);
    write_latch_set_cmd();
    run(frm(OP_PAGE_WRITE, 24'h004000, 5), 3, 0, 0, JOB_PAGE, 0, 0, 0, 0);
    // Four-line program refused, then allowed by the permit
    write_latch_set_cmd();
    run(frm(OP_QUAD_PAGE_WRITE, 24'h005020, 4), 0, 1, 0, JOB_PAGE, 0, 0, 0, 0);
    quad_mode_permit = 1'b1;
    write_latch_set_cmd();
    run(frm(OP_QUAD_PAGE_WRITE, 24'h005020, 4), 0, 1, 1, JOB_PAGE, 24'hFFFF00, msk(8'h20, 4), PC, 0);
    // Protected window blocks program, erase and whole-array erase
    protect_region_bits = 5'($random(seed)) | 5'h01;
    protect_lo = 24'h010000;
    protect_hi = 24'h01FFFF;
    write_latch_set_cmd();
    run(frm(OP_PAGE_WRITE, 24'h018800, 4), 0, 0, 0, JOB_PAGE, 0, 0, 0, 0);
    write_latch_set_cmd();
    run(frm(OP_WIPE_SECTOR, 24'h01A123, 0), 0, 0, 0, JOB_SECTOR, 0, 0, 0, 0);
    write_latch_set_cmd();
    run({OP_WIPE_ARRAY_A}, 0, 0, 0, JOB_ARRAY, 0, 0, 0, 0);
    protect_region_bits = 5'h00;
    // Every erase kind, sector and block erases at a random address
    for (int i = 0; i < 5; i++)
    begin
      a = 24'($random(seed));
      q = i > 2 ? bq_t'({ops[i]}) : frm(ops[i], a, 0);
      write_latch_set_cmd();
      run(q, 0, 0, 1, kinds[i], ams[i], 0, lens[i], 0);
    end
    // Erase frames with stray bits or a stray byte
    write_latch_set_cmd();
    run(frm(OP_WIPE_SECTOR, 24'h020000, 0), 4, 0, 0, JOB_SECTOR, 0, 0, 0, 0);
    write_latch_set_cmd();
    run({OP_WIPE_ARRAY_B, 8'h00}, 0, 0, 0, JOB_ARRAY, 0, 0, 0, 0);
    chk("jobs_left", 0, notes.size());
    end_of_test();
  end
endmodule
`default_nettype wire

/* tb/spi_host_model.sv */
// Host controller model that drives the serial flash pins
`default_nettype none
module spi_host_model (
  input wire logic clk,
  output logic select_n,
  output logic serial_clk,
  output logic [3:0] quad_io_in,
  input wire logic [3:0] dev_out,
  input wire logic [3:0] dev_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] host_io = 4'h0;
  initial
  begin
    select_n = 1'b1;
    serial_clk = 1'b0;
  end
  // Device wins where it drives; no pull, so floating lines keep flipping
  assign quad_io_in = (dev_oe & dev_out) | (~dev_oe & host_io);
  // Half of the 160 ns serial period
  task automatic half();
    repeat (10) @(posedge clk);
    #1;
  endtask
  // One serial clock; read bit taken at the end of the low phase
  task automatic unit(input logic [3:0] v, input bit quad, output logic s);
    host_io = quad ? v : {~host_io[3:1], v[0]};
    half();
    s = quad_io_in[1];
    serial_clk = 1'b1;
    half();
    serial_clk = 1'b0;
  endtask
  // Whole frame; the serial clock stands low outside it
  task automatic frame(input logic [7:0] q[$], input int tail, input bit quad, input int rd_n,
                       output logic [7:0] rd);
    int k;
    logic s;
    @(posedge clk);
    #1;
    select_n = 1'b0;
    half();
    foreach (q[i])
    begin
      if (quad && i > 0)
        for (k = 0; k < 2; k++)
          unit(q[i][7-4*k -: 4], 1'b1, s);
      else
        for (k = 0; k < 8; k++)
          unit({3'h0, q[i][7-k]}, 1'b0, s);
    end
    // Stray bits only when a refusal is wanted
    for (k = 0; k < tail; k++)
      unit(4'hF, 1'b0, s);
    for (k = 0; k < rd_n; k++)
    begin
      unit(4'h0, 1'b0, s);
      rd = {rd[6:0], s};
    end
    select_n = 1'b1;
    host_io = ~host_io;
    half();
  endtask
endmodule
`default_nettype wire
